// *** sgmii_an_regs.vh ***
// Purpose: register map and field layout of the negotiation result block
// Assumes: apb byte address is four times the register index
// Notes: definitions only
`ifndef SGMII_AN_REGS_VH
`define SGMII_AN_REGS_VH

`define AN_CTRL_INDEX 24'h1F8001
`define AN_STAT_INDEX 24'h1F8002
`define AN_CTRL_ADDR 32'h007E0004
`define AN_STAT_ADDR 32'h007E0008

`define CTRL_IRQ_EN_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_PHY_SIDE_BIT 3
`define CTRL_LINK_ADV_BIT 4
`define CTRL_RESET 16'h0004

`define MODE_SERDES 2'h0
`define MODE_SGMII 2'h2

`define STAT_DONE_BIT 0
`define STAT_DUPLEX_BIT 1
`define STAT_SPEED_LSB 2
`define STAT_SPEED_MSB 3
`define STAT_LINK_BIT 4
`define STAT_RESET 16'h0000

`endif

// *** bit_sync.v ***
// Purpose: two-flop synchroniser for levels from the pcs side
// Assumes: inputs are quasi-static levels
// Notes: only the second stage may be read
`timescale 1ns/1ps
module bit_sync #(
	parameter WIDTH = 5
) (
	input wire i_clock,
	input wire i_srst,
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // bit_sync

// *** apb_word_port.v ***
// Purpose: apb slave handshake with registered read data and error
// Assumes: zero wait states in the access phase
// Notes: read data and hit are sampled in the setup cycle
`timescale 1ns/1ps
module apb_word_port (
	input wire i_clock,
	input wire i_srst,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [15:0] i_rd_data,
	input wire i_hit,
	output wire o_pready,
	output wire [31:0] o_prdata,
	output wire o_pslverr,
	output wire o_wr_stb
);
	reg [31:0] prdata_q;
	reg slverr_q;
	wire setup;

	assign setup = i_psel & ~i_penable;

	always @(posedge i_clock)
	begin
		if (i_srst)
		begin
			prdata_q <= 32'h00000000;
			slverr_q <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= (i_hit && !i_pwrite) ? {16'h0000, i_rd_data} : 32'h00000000;
			slverr_q <= ~i_hit;
		end
	end

	assign o_pready = 1'b1;
	assign o_prdata = prdata_q;
	assign o_pslverr = slverr_q & i_psel & i_penable;
	// write lands at the access edge only, unmapped writes are dropped
	assign o_wr_stb = i_psel & i_penable & i_pwrite & ~slverr_q;
endmodule // apb_word_port

// *** sgmii_negotiation_result.v ***
// Purpose: sgmii negotiation control and result registers on apb
// Assumes: partner status inputs come from the pcs clock domain
// Notes: byte address is four times the register index
`timescale 1ns/1ps
`include "sgmii_an_regs.vh"
module sgmii_negotiation_result (
	input wire i_clock,
	input wire i_srst,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [31:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output wire [31:0] o_prdata,
	output wire o_pslverr,
	input wire i_partner_link_up,
	input wire [1:0] i_partner_speed,
	input wire i_partner_duplex,
	input wire i_an_complete,
	output wire [1:0] o_pcs_mode,
	output wire o_phy_side,
	output wire o_link_adv,
	output wire o_sgmii_mode,
	output wire o_an_irq
);
	reg [4:0] ctrl_q;
	reg done_q;
	reg done_d;
	reg complete_prev_q;
	reg [15:0] rd_data;
	reg hit;
	wire [4:0] partner_sync;
	wire wr_stb;
	wire complete_rise;
	wire sgmii_mode;
	wire [15:0] stat_word;
	wire [15:0] ctrl_reset;

	// only the implemented control bits take the reset word
	assign ctrl_reset = `CTRL_RESET;

	bit_sync #(
		.WIDTH(5)
	) u_sync (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_async({i_an_complete, i_partner_link_up, i_partner_speed, i_partner_duplex}),
		.o_sync(partner_sync)
	);

	apb_word_port u_apb (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_rd_data(rd_data),
		.i_hit(hit),
		.o_pready(o_pready),
		.o_prdata(o_prdata),
		.o_pslverr(o_pslverr),
		.o_wr_stb(wr_stb)
	);

	// address decode and read mux
	always @*
	begin
		hit = 1'b0;
		rd_data = 16'h0000;
		case (i_paddr)
			`AN_CTRL_ADDR:
			begin
				hit = 1'b1;
				rd_data = {11'h000, ctrl_q};
			end
			`AN_STAT_ADDR:
			begin
				hit = 1'b1;
				rd_data = stat_word;
			end
			default:
			begin
				hit = 1'b0;
				rd_data = 16'h0000;
			end
		endcase
	end

	// control register
	always @(posedge i_clock)
	begin
		if (i_srst)
			ctrl_q <= ctrl_reset[4:0];
		else if (wr_stb && i_paddr == `AN_CTRL_ADDR)
			ctrl_q <= i_pwdata[4:0];
	end

	assign sgmii_mode = (ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_SGMII);

	// completion edge seen after the synchroniser
	always @(posedge i_clock)
	begin
		if (i_srst)
			complete_prev_q <= 1'b0;
		else
			complete_prev_q <= partner_sync[4];
	end

	assign complete_rise = partner_sync[4] & ~complete_prev_q;

	// sticky flag, a new completion wins over a clear in the same cycle
	always @*
	begin
		done_d = done_q;
		if (wr_stb && i_paddr == `AN_STAT_ADDR && !i_pwdata[`STAT_DONE_BIT])
			done_d = 1'b0;
		if (complete_rise)
			done_d = 1'b1;
	end

	always @(posedge i_clock)
	begin
		if (i_srst)
			done_q <= 1'b0;
		else
			done_q <= done_d;
	end

	// partner fields only shown in sgmii mode
	assign stat_word = {11'h000,
		sgmii_mode & partner_sync[3],
		sgmii_mode ? partner_sync[2:1] : 2'h0,
		sgmii_mode & partner_sync[0],
		done_q};

	assign o_an_irq = done_q & ctrl_q[`CTRL_IRQ_EN_BIT];
	assign o_pcs_mode = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	assign o_phy_side = ctrl_q[`CTRL_PHY_SIDE_BIT];
	assign o_link_adv = ctrl_q[`CTRL_LINK_ADV_BIT];
	assign o_sgmii_mode = sgmii_mode;
endmodule // sgmii_negotiation_result

// *** sgmii_neg_props.sv ***
// Purpose: port checks of the negotiation result block
// Assumes: register map header
// Notes: bound below
`timescale 1ns/1ps
`include "sgmii_an_regs.vh"
module sgmii_neg_props(
	input wire i_clock,
	input wire i_srst,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [31:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire o_pslverr,
	input wire i_an_complete,
	input wire [1:0] o_pcs_mode,
	input wire o_sgmii_mode,
	input wire o_an_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	wire acc = i_psel & i_penable;
	wire setup = i_psel & ~i_penable;
	wire bad = (i_paddr != `AN_STAT_ADDR) && (i_paddr != `AN_CTRL_ADDR);
	wire cw = acc & i_pwrite & (i_paddr == `AN_CTRL_ADDR);
	wire clr = acc & i_pwrite & (i_paddr == `AN_STAT_ADDR) & ~i_pwdata[0];
	mode_decode_a: assert property ($stable(o_pcs_mode) |-> o_sgmii_mode == (o_pcs_mode == 2'h2))
		else $error("mode decode");
	reset_value_a: assert property ($past(i_srst) |-> o_pcs_mode == 2'h2 && !o_an_irq)
		else $error("reset value");
	flag_hold_a: assert property (o_an_irq && !clr && !cw |=> o_an_irq)
		else $error("flag lost");
	flag_clear_a: assert property (clr && !$past(i_an_complete, 2) |=> !o_an_irq)
		else $error("flag not cleared");
	irq_cause_a: assert property ($rose(o_an_irq) |-> $past(cw) || $past(i_an_complete, 3))
		else $error("irq without cause");
	slverr_a: assert property (o_pslverr == (acc && bad))
		else $error("slverr wrong");
	upper_zero_a: assert property (setup |=> o_prdata[31:5] == 27'h0)
		else $error("upper bits set");
	serdes_zero_a: assert property (setup && i_paddr == `AN_STAT_ADDR && !o_sgmii_mode |=> o_prdata[4:1] == 4'h0)
		else $error("fields not zero");
	cover property ($rose(o_an_irq));
	cover property (clr);
	cover property (o_pslverr);
endmodule // sgmii_neg_props
bind sgmii_negotiation_result sgmii_neg_props props(.*);

// *** sgmii_partner.sv ***
// Purpose: phy-side partner reporting negotiation results
// Assumes: bench pulses i_go per exchange
// Notes: completion drops at each restart
`timescale 1ns/1ps
module sgmii_partner(
	input wire i_clock,
	input wire i_go,
	input wire [3:0] i_res,
	input wire [3:0] i_wait,
	output logic o_link,
	output logic [1:0] o_speed,
	output logic o_duplex,
	output logic o_done
);
	logic [3:0] cnt_q = 4'h0;
	initial {o_link, o_speed, o_duplex, o_done} = 5'h0;
	always @(posedge i_clock)
	begin
		if (i_go)
		begin
			cnt_q <= i_wait;
			o_done <= 1'b0;
			{o_link, o_speed, o_duplex} <= i_res;
		end
		else if (cnt_q != 4'h0)
		begin
			cnt_q <= cnt_q - 4'h1;
			o_done <= cnt_q == 4'h1;
		end
	end
endmodule // sgmii_partner

// *** testbench.sv ***
// Purpose: self-checking bench of the negotiation result block
// Assumes: zero wait apb slave
// Notes: fixed seed
`timescale 1ns/1ps
`include "sgmii_an_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module testbench;
	logic i_clock = 0, i_srst = 1, psel = 0, pen = 0, pw = 0, go = 0, e;
	logic [31:0] pa = 0, wd = 0, rd;
	logic [3:0] res = 0, wt = 1;
	wire rdy, err, lk, dp, dn, irq, sg;
	wire [1:0] sp, md;
	wire [31:0] prd;
	int num_errors = 0, n_compared = 0, i, k;
	always #5 i_clock = ~i_clock;
	sgmii_partner ph(.i_clock(i_clock), .i_go(go), .i_res(res), .i_wait(wt), .o_link(lk),
		.o_speed(sp), .o_duplex(dp), .o_done(dn));
	sgmii_negotiation_result uut(.i_clock(i_clock), .i_srst(i_srst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(wd), .o_pready(rdy),
		.o_prdata(prd), .o_pslverr(err), .i_partner_link_up(lk), .i_partner_speed(sp),
		.i_partner_duplex(dp), .i_an_complete(dn), .o_pcs_mode(md), .o_phy_side(),
		.o_link_adv(), .o_sgmii_mode(sg), .o_an_irq(irq));
	function automatic [31:0] st(input logic [3:0] r, input logic f);
		st = {27'h0, r, f};
	endfunction
	task finish_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		psel <= 1; pw <= w; pa <= a; wd <= d;
		@(posedge i_clock);
		pen <= 1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge i_clock);
			if (rdy === 1'b1) break;
		end
		rd = prd; e = err;
		if (n == 20) begin num_errors++; finish_test; end
		psel <= 0; pen <= 0;
		@(posedge i_clock);
	endtask
	initial
	begin
		void'($urandom(32'h6048FC4E));
		repeat (6) @(posedge i_clock);
		i_srst <= 0;
		@(posedge i_clock);
		apb(0, `AN_CTRL_ADDR, 0); `CHK(rd, 32'h4)
		apb(0, `AN_STAT_ADDR, 0); `CHK(rd, 32'h0)
		for (i = 0; i < 6; i++)
		begin
			res <= $urandom; wt <= 4'($urandom_range(1, 15)); go <= 1;
			@(posedge i_clock);
			go <= 0;
			for (k = 0; k < 30 && !rd[0]; k++) apb(0, `AN_STAT_ADDR, 0);
			`CHK(rd, st(res, 1))
			apb(1, `AN_STAT_ADDR, 32'hFFFFFFFF); apb(0, `AN_STAT_ADDR, 0);
			`CHK(rd, st(res, 1))
			apb(1, `AN_CTRL_ADDR, 32'h5); `CHK(irq, 1'b1)
			apb(1, `AN_STAT_ADDR, 0); apb(0, `AN_STAT_ADDR, 0);
			`CHK(rd, st(res, 0))
			`CHK(irq, 1'b0)
			apb(1, `AN_CTRL_ADDR, 32'h4);
		end
		for (i = 0; i < 4; i++)
		begin
			apb(1, `AN_CTRL_ADDR, 32'(i * 2)); apb(0, `AN_STAT_ADDR, 0);
			`CHK(rd, (i == 2) ? st(res, 0) : 32'h0)
			`CHK(sg, i == 2)
		end
		apb(0, 32'h007E000C, 0); `CHK({e, rd}, {1'b1, 32'h0})
		finish_test;
	end
endmodule // testbench
